// file: hdl/cam_top.sv
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Function
// - Capture bits set put module in capture
// - Valid edge copies counter into compare bytes
// - Interrupt needs event flag and irq enable
// - Enabled comparator signals match on equality
// - Compare low write clears comparator enable
// - Compare high write sets comparator enable
// - Comparator enable also written via mode register
// - Flip, match, comparator bits select toggle mode
// - Toggle mode inverts pin on each match
// - All PWM outputs share one counter period
// - PWM low below compare low, else high
// - Low byte wrap reloads low from high
// - PWM needs PWM bit and comparator enable
// - Sysclk source: step is prescale plus one
// - Only module four offers the watchdog
// - Watchdog match issues internal reset
// - Watchdog reset never drives reset pin
// - Falling, rising or both edges trigger capture
// - Match sets flag only with both enables
module cam_top
	import cam_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [4:0] module_io_pin_i,
	output logic [4:0] module_io_pin_o,
	output logic [4:0] module_io_pin_oe_o,
	output logic irq_o,
	output logic wdt_reset_o
);

	////////////////////////////////////////////////////////////////////////
	// Decode helper

	// One-hot module select for a per-module block, zero if out of range
	function automatic logic [4:0] mod_hit(input logic [7:0] adr,
		input logic [2:0] blk);
		logic [4:0] hit;
		hit = 5'h00;
		if (adr[7:5] == blk && adr[4:2] < 3'(NUM_MOD)) begin
			hit = 5'h01 << adr[4:2];
		end
		return hit;
	endfunction : mod_hit

	////////////////////////////////////////////////////////////////////////
	// State

	logic ack_q; // Bus acknowledge
	logic [31:0] rdat_q; // Read data latched with the acknowledge
	logic [7:0] ctrl_q; // Run, source, watchdog enable, prescale
	logic [4:0] flag_q; // Module event flags
	logic [15:0] cnt_q; // Shared counter
	logic step_q; // Counter moved in the previous cycle
	logic [7:0] mode_q [NUM_MOD]; // Module mode control
	logic [7:0] lo_q [NUM_MOD]; // Compare value low bytes
	logic [7:0] hi_q [NUM_MOD]; // Compare value high bytes
	logic [4:0] pin_q; // Pin output levels
	logic [4:0] oe_q; // Pin output enables
	logic irq_q;
	logic wdt_q;

	// Next values
	logic [7:0] mode_d [NUM_MOD]; // Mode after writes and auto enable
	logic [7:0] lo_d [NUM_MOD]; // Low byte after write, capture, reload
	logic [7:0] hi_d [NUM_MOD]; // High byte after write or capture
	logic [4:0] pin_d; // Pin levels for the next cycle
	logic [4:0] oe_d; // Pin drive for the next cycle
	logic [4:0] flag_set; // Flags raised this cycle
	logic [4:0] flag_d; // Flags after clear and set
	logic [15:0] cnt_d; // Counter after write or step
	logic [4:0] match_ev; // Enabled equality, one pulse per count
	logic [4:0] irq_en; // Irq enable bits gathered
	logic tick; // Counter step strobe

	////////////////////////////////////////////////////////////////////////
	// Wishbone decode

	logic req; // Request present and not yet answered
	logic wr; // Write takes effect at the acknowledge edge
	logic [7:0] wdat; // Write byte, low lane
	logic [4:0] wr_mode;
	logic [4:0] wr_lo;
	logic [4:0] wr_hi;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_cnt_lo;
	logic wr_cnt_hi;
	logic [2:0] ridx; // Module index of the read
	logic [4:0] rd_mod; // Per-module read hits
	logic [7:0] rd_byte;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	// Only the low lane carries register data; other lanes are ignored
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
	assign wdat = wb_dat_i[7:0];
	// Shared register hits, decoded once for reads and writes
	logic hit_ctrl; // Control register
	logic hit_stat; // Status register
	logic hit_cnt_lo; // Counter low byte
	logic hit_cnt_hi; // Counter high byte
	assign hit_ctrl = (wb_adr_i == OFS_CTRL);
	assign hit_stat = (wb_adr_i == OFS_STAT);
	assign hit_cnt_lo = (wb_adr_i == OFS_CNT_LOW);
	assign hit_cnt_hi = (wb_adr_i == OFS_CNT_HIGH);
	assign wr_ctrl = wr && hit_ctrl;
	assign wr_stat = wr && hit_stat;
	assign wr_cnt_lo = wr && hit_cnt_lo;
	assign wr_cnt_hi = wr && hit_cnt_hi;
	assign wr_mode = wr ? mod_hit(wb_adr_i, BLK_MODE) : 5'h00;
	assign wr_lo = wr ? mod_hit(wb_adr_i, BLK_CMP_LOW) : 5'h00;
	assign wr_hi = wr ? mod_hit(wb_adr_i, BLK_CMP_HIGH) : 5'h00;

	// Read selection; unmapped offsets read as zero
	logic [2:0] rblk; // Register block of the read
	logic [7:0] rd_shared; // Value when a shared register is hit
	logic [7:0] rd_module; // Value when a module register is hit
	assign ridx = wb_adr_i[4:2];
	assign rblk = wb_adr_i[7:5];
	assign rd_mod = mod_hit(wb_adr_i, rblk);
	assign rd_shared =
		hit_ctrl ? ctrl_q :
		hit_stat ? {3'h0, flag_q} :
		hit_cnt_lo ? cnt_q[7:0] :
		hit_cnt_hi ? cnt_q[15:8] : 8'h00;
	// Index is only used once the module hit says it is in range
	assign rd_module =
		(rd_mod == 5'h00) ? 8'h00 :
		(rblk == BLK_MODE) ? mode_q[ridx] :
		(rblk == BLK_CMP_LOW) ? lo_q[ridx] :
		(rblk == BLK_CMP_HIGH) ? hi_q[ridx] : 8'h00;
	// Shared offsets sit in block zero, where no module register lives
	assign rd_byte = (rblk == BLK_MISC) ? rd_shared : rd_module;

	// Acknowledge one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			rdat_q <= req ? {24'h00_0000, rd_byte} : rdat_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter time base

	cam_tick u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(ctrl_q[CTRL_RUN]),
		.src_i(ctrl_q[CTRL_SRC_LSB +: 2]),
		.prescale_i(ctrl_q[CTRL_PRE_LSB +: 4]),
		.tick_o(tick)
	);

	// Software writes win over a step so a reload is never lost
	assign cnt_d = wr_cnt_lo ? {cnt_q[15:8], wdat} :
		wr_cnt_hi ? {wdat, cnt_q[7:0]} :
		tick ? 16'(cnt_q + 16'h0001) : cnt_q;

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser

	cam_pin_if pins ();

	assign pins.raw = module_io_pin_i;

	cam_pin_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pins(pins)
	);

	////////////////////////////////////////////////////////////////////////
	// Per-module logic

	// A counter write in the wrap cycle still reloads the PWM bytes
	logic wrap; // Low byte steps from its maximum to zero
	assign wrap = tick && (cnt_q[7:0] == CNT_LOW_MAX);

	for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
		logic cmp_en; // Comparator enable
		logic cap_on; // Any capture edge enabled
		logic cap_ev; // Capture event this cycle
		logic pwm_on; // PWM mode active
		logic hso_on; // Toggle output mode active
		logic cmp_en_n;

		assign cmp_en = mode_q[m][MODE_CMP_EN];
		assign cap_on = mode_q[m][MODE_RISE] || mode_q[m][MODE_FALL];
		assign cap_ev = (pins.rise[m] && mode_q[m][MODE_RISE]) ||
			(pins.fall[m] && mode_q[m][MODE_FALL]);
		assign pwm_on = mode_q[m][MODE_PWM] && cmp_en;
		assign hso_on = mode_q[m][MODE_FLIP] && mode_q[m][MODE_MATCH] &&
			cmp_en;

		// Equality checked once per count, the cycle after the step
		assign match_ev[m] = step_q && cmp_en && !mode_q[m][MODE_PWM] &&
			(cnt_q == {hi_q[m], lo_q[m]});

		// Mode register write beats the automatic enable changes
		assign cmp_en_n = wr_mode[m] ? wdat[MODE_CMP_EN] :
			wr_lo[m] ? 1'b0 :
			wr_hi[m] ? 1'b1 : cmp_en;
		assign mode_d[m] = wr_mode[m] ? {1'b0, wdat[6:0]} :
			{1'b0, cmp_en_n, mode_q[m][5:0]};

		// Compare bytes: write, capture, then PWM reload
		assign lo_d[m] = wr_lo[m] ? wdat :
			(cap_ev && !pwm_on) ? cnt_q[7:0] :
			(pwm_on && wrap) ? hi_q[m] : lo_q[m];
		assign hi_d[m] = wr_hi[m] ? wdat :
			(cap_ev && !pwm_on) ? cnt_q[15:8] : hi_q[m];

		// Captures flag outside PWM mode; matches only with the match bit
		assign flag_set[m] = (cap_ev && !pwm_on) ||
			(match_ev[m] && mode_q[m][MODE_MATCH]);

		// PWM compares the shared low byte, so every output shares a period
		assign pin_d[m] = pwm_on ?
			(cnt_q[7:0] >= lo_q[m]) :
			(hso_on && match_ev[m]) ? !pin_q[m] : pin_q[m];

		// Drive the pin only in the output modes; capture leaves it input
		assign oe_d[m] = (pwm_on || hso_on) && !cap_on;
		assign irq_en[m] = mode_q[m][MODE_IRQ_EN];
	end

	////////////////////////////////////////////////////////////////////////
	// Flags and interrupt

	// Writing zero clears a flag; a set in the same cycle wins
	assign flag_d = (flag_q & (wr_stat ? wdat[4:0] : 5'h1F)) | flag_set;

	////////////////////////////////////////////////////////////////////////
	// Register update

	// Control register, written only by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= RST_CTRL;
		end else begin
			ctrl_q <= wr_ctrl ? wdat : ctrl_q;
		end
	end

	// Event flags; captures and matches set, software clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= RST_FLAGS;
		end else begin
			flag_q <= flag_d;
		end
	end

	// Shared counter and the step seen by the comparators
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= RST_CNT;
			step_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			step_q <= tick;
		end
	end

	// Pin level and drive, registered so the pads never glitch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 5'h00;
			oe_q <= 5'h00;
		end else begin
			pin_q <= pin_d;
			oe_q <= oe_d;
		end
	end

	// Interrupt line lags the flags by one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flag_q & irq_en);
		end
	end

	// Watchdog only on module four, with match bit and enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_q <= 1'b0;
		end else begin
			wdt_q <= ctrl_q[CTRL_WDT_EN] && match_ev[WDT_MOD] &&
				mode_q[WDT_MOD][MODE_MATCH];
		end
	end

	// Per-module mode registers
	always_ff @(posedge clk_i) begin
		for (int m = 0; m < NUM_MOD; m++) begin
			if (rst_i) begin
				mode_q[m] <= RST_MODE;
			end else begin
				mode_q[m] <= mode_d[m];
			end
		end
	end

	// Per-module compare bytes
	always_ff @(posedge clk_i) begin
		for (int m = 0; m < NUM_MOD; m++) begin
			if (rst_i) begin
				lo_q[m] <= RST_CMP;
				hi_q[m] <= RST_CMP;
			end else begin
				lo_q[m] <= lo_d[m];
				hi_q[m] <= hi_d[m];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign module_io_pin_o = pin_q;
	assign module_io_pin_oe_o = oe_q;
	assign irq_o = irq_q;
	// Internal reset request only; no path reaches the board reset pin
	assign wdt_reset_o = wdt_q;

endmodule : cam_top

// file: hdl/cam_pkg.sv
package cam_pkg;

	// Module count and the one module that may act as watchdog
	localparam int NUM_MOD = 5;
	localparam logic [2:0] WDT_MOD = 3'h4;

	// Byte offsets of the shared registers, one aligned word each
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_CNT_LOW = 8'h08;
	localparam logic [7:0] OFS_CNT_HIGH = 8'h0C;

	// Per-module register blocks: byte address bits 7:5 pick the block
	localparam logic [2:0] BLK_MISC = 3'h0;
	localparam logic [2:0] BLK_MODE = 3'h1;
	localparam logic [2:0] BLK_CMP_LOW = 3'h2;
	localparam logic [2:0] BLK_CMP_HIGH = 3'h3;

	// Array control register fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_SRC_LSB = 1;
	localparam int CTRL_WDT_EN = 3;
	localparam int CTRL_PRE_LSB = 4;
	localparam logic [1:0] SRC_SYSCLK = 2'h0;

	// Module mode control fields
	localparam int MODE_IRQ_EN = 0;
	localparam int MODE_PWM = 1;
	localparam int MODE_FLIP = 2;
	localparam int MODE_MATCH = 3;
	localparam int MODE_FALL = 4;
	localparam int MODE_RISE = 5;
	localparam int MODE_CMP_EN = 6;

	// Values after reset
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CMP = 8'h00;
	localparam logic [15:0] RST_CNT = 16'h0000;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [3:0] RST_PRE = 4'h0;

	// Low byte value at which the counter wraps
	localparam logic [7:0] CNT_LOW_MAX = 8'hFF;

endpackage : cam_pkg

// file: hdl/cam_pin_if.sv
`timescale 1ns/1ps
// Raw module pin levels and their synchronised edges
interface cam_pin_if;
	logic [4:0] raw; // Pin levels straight from the pads
	logic [4:0] rise; // One-cycle pulse on a settled rising edge
	logic [4:0] fall; // One-cycle pulse on a settled falling edge
	modport sync (input raw, output rise, output fall);
	modport user (output raw, input rise, input fall);
endinterface : cam_pin_if

// file: hdl/cam_pin_sync.sv
`timescale 1ns/1ps
module cam_pin_sync
	import cam_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	cam_pin_if.sync pins
);

	logic [4:0] s1_q; // First stage, read only by the second
	logic [4:0] s2_q; // Second stage
	logic [4:0] s3_q; // Third stage
	logic [4:0] lvl_q; // Accepted level
	logic [4:0] agree; // Second and third stages agree
	logic [4:0] lvl_d;

	////////////////////////////////////////////////////////////////////////
	// A change counts only once two stages agree, filtering one-cycle spikes
	assign agree = ~(s2_q ^ s3_q);
	assign lvl_d = (agree & s3_q) | (~agree & lvl_q);

	// Three-stage synchroniser and accepted level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			s3_q <= 5'h00;
			lvl_q <= 5'h00;
		end else begin
			s1_q <= pins.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// Edges from successive accepted samples
	assign pins.rise = lvl_d & ~lvl_q;
	assign pins.fall = ~lvl_d & lvl_q;

endmodule : cam_pin_sync

// file: hdl/cam_tick.sv
`timescale 1ns/1ps
module cam_tick
	import cam_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [1:0] src_i,
	input wire logic [3:0] prescale_i,
	output logic tick_o
);

	logic [3:0] pre_q; // Clocks spent in the current step
	logic tick_q;
	logic active;
	logic last;

	////////////////////////////////////////////////////////////////////////
	// Only the system-clock source is built; other sources hold the count
	assign active = run_i && (src_i == SRC_SYSCLK);
	assign last = (pre_q == prescale_i);

	// One step every prescale plus one clocks
	always_ff @(posedge clk_i) begin
		if (rst_i || !active) begin
			pre_q <= RST_PRE;
			tick_q <= 1'b0;
		end else begin
			pre_q <= last ? RST_PRE : 4'(pre_q + 4'h1);
			tick_q <= last;
		end
	end

	assign tick_o = tick_q;

endmodule : cam_tick

// file: tb/cam_props.sv
`timescale 1ns/1ps
module cam_props
	import cam_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [4:0] module_io_pin_o,
	input wire logic [4:0] module_io_pin_oe_o,
	input wire logic irq_o,
	input wire logic wdt_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire rd_ack = wb_ack_o && !wb_we_i; // Read answer
	wire wr_ack = wb_ack_o && wb_we_i; // Write taking effect
	////////////////////////////////////////////////////////////////////
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("late ack");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
	property p_rd_upper; rd_ack |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper bits");
	property p_unmapped; rd_ack && wb_adr_i[7] |-> wb_dat_o == 0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("hole read");
	property p_mode_b7;
		rd_ack && wb_adr_i[7:5] == BLK_MODE |-> !wb_dat_o[7];
	endproperty
	a_mode_b7: assert property (p_mode_b7) else $error("mode b7");
	property p_wdt_pulse; wdt_reset_o |=> !wdt_reset_o; endproperty
	a_wdt_pulse: assert property (p_wdt_pulse) else $error("wdt");
	// Outputs start quiet after every reset release
	property p_quiet;
		$past(rst_i) |-> !irq_o && !wdt_reset_o && module_io_pin_oe_o == 0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("not quiet");
	// Pin drive only moves after software changed a mode
	property p_oe_cause;
		$changed(module_io_pin_oe_o) |-> $past(wr_ack) || $past(wr_ack, 2)
			|| $past(wr_ack, 3);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("oe");
	c_wdt: cover property (wdt_reset_o);
	c_irq: cover property ($rose(irq_o));
	c_flip: cover property ($changed(module_io_pin_o));
endmodule : cam_props

bind cam_top cam_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.module_io_pin_o(module_io_pin_o),
	.module_io_pin_oe_o(module_io_pin_oe_o),
	.irq_o(irq_o), .wdt_reset_o(wdt_reset_o));

// file: tb/cam_pin_model.sv
`timescale 1ns/1ps
// Outside source on the pins; follows the wanted level after a lag
module cam_pin_model (
	input wire logic clk_i,
	input wire logic [4:0] want_i,
	input wire logic [1:0] lag_i,
	output logic [4:0] pin_o
);
	int wait_q = 0; // Cycles spent lagging
	initial pin_o = 5'h00;
	// Slow sources keep the old level for a few cycles
	always @(posedge clk_i) begin
		if (pin_o === want_i) begin
			wait_q <= 0;
		end else if (wait_q >= lag_i) begin
			pin_o <= want_i;
			wait_q <= 0;
		end else begin
			wait_q <= wait_q + 1;
		end
	end
endmodule : cam_pin_model

// file: tb/cam_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
	miscompares++; $display("mismatch %s exp %h seen %h", n, e, a); end end
module cam_top_tb
	import cam_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [4:0] want = 5'h00; // Wanted outside pin levels
	logic [1:0] lag = 2'h0; // Outside source slowness
	logic [31:0] rdat, q;
	logic ack, irq, wdt;
	logic [4:0] pin_o, oe, ext, pin_w;
	logic [7:0] cap_mode [5] = '{8'h20, 8'h10, 8'h30, 8'h30, 8'h10};
	int miscompares = 0;
	int n_checks = 0;
	int wdt_n = 0; // Watchdog pulses seen
	assign pin_w = (oe & pin_o) | (~oe & ext); // Resolved pad levels
	initial forever #2 clk_i = ~clk_i;
	always @(negedge clk_i) if (wdt === 1'b1) wdt_n++;
	cam_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.module_io_pin_i(pin_w), .module_io_pin_o(pin_o),
		.module_io_pin_oe_o(oe), .irq_o(irq), .wdt_reset_o(wdt));
	cam_pin_model far (.clk_i(clk_i), .want_i(want), .lag_i(lag),
		.pin_o(ext));
	////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	// Classic cycle held until ack is seen at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		i = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			i++;
		end while (ack !== 1'b1 && i < 64);
		q = rdat;
		if (i >= 64) begin
			miscompares++;
			print_verdict();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	function automatic logic [7:0] ra(input logic [2:0] b, input int n);
		return {b, 3'(n), 2'h0};
	endfunction : ra
	task do_reset;
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask : do_reset
	////////////////////////////////////////////////////////////////////
	initial begin
		int n, k, v, p, c, h;
		int hv [3];
		int cnt [3];
		void'($urandom(13328));
		@(posedge clk_i);
		do_reset();
		for (n = 0; n < NUM_MOD; n++) begin
			bus(0, ra(BLK_MODE, n), 0);
			`CHK("mode", RST_MODE, q[7:0])
			bus(1, ra(BLK_MODE, n), 8'h48);
			bus(1, ra(BLK_CMP_LOW, n), 8'($urandom));
			bus(0, ra(BLK_MODE, n), 0);
			`CHK("mode_lo", 8'h08, q[7:0])
			bus(1, ra(BLK_CMP_HIGH, n), 8'($urandom));
			bus(0, ra(BLK_MODE, n), 0);
			`CHK("mode_hi", 8'h48, q[7:0])
		end
		bus(1, 8'hE0, 8'h5A);
		bus(0, 8'hE0, 0);
		`CHK("hole", 32'h0, q)
		$display("test registers done");
		// Halted counter captured on each enabled edge kind
		do_reset();
		n = $urandom % NUM_MOD;
		c = 0;
		for (k = 0; k < 5; k++) begin
			lag <= 2'($urandom);
			v = $urandom % 65536;
			bus(1, OFS_CNT_LOW, v[7:0]);
			bus(1, OFS_CNT_HIGH, v[15:8]);
			bus(1, OFS_STAT, 8'h00);
			bus(1, ra(BLK_MODE, n), cap_mode[k]);
			want[n] <= ~k[0];
			repeat (12) @(posedge clk_i);
			if (k < 4) c = v;
			bus(0, OFS_STAT, 0);
			`CHK("cap_flag", k < 4, q[n])
			bus(0, ra(BLK_CMP_LOW, n), 0);
			`CHK("cap_lo", c[7:0], q[7:0])
			bus(0, ra(BLK_CMP_HIGH, n), 0);
			`CHK("cap_hi", c[15:8], q[7:0])
		end
		$display("test capture done");
		// Matches on two modules, only one with flag enable
		do_reset();
		n = $urandom % 3;
		v = $urandom % 65000;
		p = $urandom % 4;
		c = v + 3;
		bus(1, OFS_CNT_LOW, v[7:0]);
		bus(1, OFS_CNT_HIGH, v[15:8]);
		for (k = 0; k < 2; k++) begin
			bus(1, ra(BLK_MODE, n + k), k ? 8'h01 : 8'h0D);
			bus(1, ra(BLK_CMP_LOW, n + k), c[7:0]);
			bus(1, ra(BLK_CMP_HIGH, n + k), c[15:8]);
		end
		c = wdt_n;
		`CHK("irq0", 1'b0, irq)
		bus(1, OFS_CTRL, 8'(p * 16 + 9));
		for (h = 0; h < 200 && irq !== 1'b1; h++) begin
			@(negedge clk_i);
		end
		`CHK("irq", 1'b1, irq)
		`CHK("flip", 5'(1 << n), pin_o & oe)
		@(posedge clk_i);
		bus(0, OFS_STAT, 0);
		`CHK("flags", 5'(1 << n), q[4:0])
		`CHK("no_wdt", c, wdt_n)
		bus(1, OFS_STAT, 8'h00);
		repeat (3) @(posedge clk_i);
		`CHK("irq_clr", 1'b0, irq)
		$display("test compare done");
		// Module four match with the watchdog bit clear, then set
		do_reset();
		bus(1, OFS_CNT_LOW, 8'h10);
		bus(1, ra(BLK_MODE, WDT_MOD), 8'h08);
		bus(1, ra(BLK_CMP_LOW, WDT_MOD), 8'h14);
		bus(1, ra(BLK_CMP_HIGH, WDT_MOD), 8'h00);
		c = wdt_n;
		// Watchdog held off while the count runs through the match
		bus(1, OFS_CTRL, 8'h01);
		repeat (30) @(posedge clk_i);
		`CHK("wdt_off", c, wdt_n)
		bus(1, OFS_CTRL, 8'h00);
		bus(1, OFS_CNT_LOW, 8'h10);
		bus(1, OFS_CTRL, 8'h09);
		repeat (30) @(posedge clk_i);
		`CHK("wdt", c + 1, wdt_n)
		$display("test watchdog done");
		// PWM pair sharing the period, third module lacks the enable
		do_reset();
		p = $urandom % 3;
		for (k = 0; k < 3; k++) begin
			hv[k] = 1 + $urandom % 255;
			cnt[k] = 0;
			bus(1, ra(BLK_MODE, k), 8'h42);
			bus(1, ra(BLK_CMP_LOW, k), 8'($urandom));
			bus(1, ra(BLK_CMP_HIGH, k), 8'(hv[k]));
		end
		bus(1, ra(BLK_MODE, 2), 8'h02);
		bus(1, OFS_CTRL, 8'(p * 16 + 1));
		repeat (300 * (p + 1)) @(posedge clk_i);
		repeat (256 * (p + 1)) begin
			@(negedge clk_i);
			for (k = 0; k < 3; k++) begin
				if ((pin_o[k] & oe[k]) === 1'b1) cnt[k]++;
			end
		end
		for (k = 0; k < 2; k++) begin
			`CHK("pwm", (256 - hv[k]) * (p + 1), cnt[k])
		end
		`CHK("pwm_off", 0, cnt[2])
		$display("test pwm done");
		print_verdict();
	end
endmodule : cam_top_tb
